/* hdl/eoc_top.sv */
/*
 External oscillator control: the control register, the mode decode that
 enables the analog drive circuit and claims its port pins, the crystal
 valid flag and the divided timer clock enable.
 Assumes a register port with one-cycle strobes, an analog oscillator that
 returns its raw clock and an amplitude-good level, and port logic that
 honours the pin claims.
*/
// Contract
// - Crystal or resonator mode claims P0.2 as input and P0.3 as output pin.
// - Capacitor, RC or CMOS clock mode claims only P0.3.
// - Oscillator divided by eight is offered to timers and counter array; the two halved modes divide it by sixteen.
// - Divided clock is synchronised to the core clock, jitter within one core clock cycle.
// - Crystal valid flag reads zero until amplitude settles, then one.
// - Mode values 00x switch the oscillator circuit off.
// - Modes decode as CMOS, CMOS halved, RC, capacitor, crystal, crystal halved.
`timescale 1ns/100ps
`include "eoc_map.svh"

module eoc_top
   import eoc_pkg::*;
#(
   parameter int QUAL_CYCLES = `EOC_QUAL_CYCLES,
   parameter int TIMER_DIV   = `EOC_TIMER_DIV
) (
   input  wire logic                   clock,
   input  wire logic                   rstn,
   input  wire logic                   ce,
   input  wire logic [`EOC_ADDR_W-1:0] addr,
   input  wire logic [`EOC_DATA_W-1:0] wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [`EOC_DATA_W-1:0] rdata,
   input  wire logic                   osc_raw,
   input  wire logic                   amp_ok,
   output logic                        osc_enable,
   output logic                        crystal_sel,
   output logic                        rc_sel,
   output logic                        cap_sel,
   output logic                        cmos_sel,
   output logic                        halve_sel,
   output logic      [2:0]             drive_range_select,
   output logic                        osc_input_pin_claim,
   output logic                        osc_output_pin_claim,
   output logic                        crystal_valid_flag,
   output logic                        timer_tick
);

   localparam int QW = $clog2(QUAL_CYCLES + 1);

   generate
      if (QUAL_CYCLES < 1) begin : g_bad_qual
         $error("QUAL_CYCLES must be at least 1.");
      end
      if (TIMER_DIV < 2) begin : g_bad_div
         $error("TIMER_DIV must be at least 2.");
      end
   endgenerate

   typedef struct packed {
      eoc_mode_t             mode;
      logic [2:0]            range;
      logic [2:0]            amp_sync;
      logic                  amp_level;
      logic [QW-1:0]         qual_cnt;
      logic                  valid;
      logic [`EOC_DATA_W-1:0] rdata;
      logic                  osc_enable;
      logic                  crystal_sel;
      logic                  rc_sel;
      logic                  cap_sel;
      logic                  cmos_sel;
      logic                  halve_sel;
      logic [2:0]            drive_range;
      logic                  in_claim;
      logic                  out_claim;
      logic                  tick;
   } eoc_state_t;

   eoc_state_t state;
   eoc_state_t next_state;

   logic       div_tick;
   logic       dec_on;
   logic       dec_xtal;
   logic       dec_rc;
   logic       dec_cap;
   logic       dec_cmos;
   logic       dec_half;
   logic [7:0] ctrl_view;

   // Mode decode of the current register contents.
   always_comb begin
      dec_on   = 1'b0;
      dec_xtal = 1'b0;
      dec_rc   = 1'b0;
      dec_cap  = 1'b0;
      dec_cmos = 1'b0;
      dec_half = 1'b0;
      unique case (state.mode)
         EOC_MODE_OFF_A, EOC_MODE_OFF_B: begin
            dec_on = 1'b0;
         end
         EOC_MODE_CMOS: begin
            dec_on   = 1'b1;
            dec_cmos = 1'b1;
         end
         EOC_MODE_CMOS_HALF: begin
            dec_on   = 1'b1;
            dec_cmos = 1'b1;
            dec_half = 1'b1;
         end
         EOC_MODE_RC: begin
            dec_on = 1'b1;
            dec_rc = 1'b1;
         end
         EOC_MODE_CAP: begin
            dec_on  = 1'b1;
            dec_cap = 1'b1;
         end
         EOC_MODE_XTAL: begin
            dec_on   = 1'b1;
            dec_xtal = 1'b1;
         end
         EOC_MODE_XTAL_HALF: begin
            dec_on   = 1'b1;
            dec_xtal = 1'b1;
            dec_half = 1'b1;
         end
      endcase
   end

   // Register image as software sees it; the reserved bit reads as zero.
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[`EOC_VALID_BIT] = state.valid;
      ctrl_view[`EOC_MODE_HI:`EOC_MODE_LO] = state.mode;
      ctrl_view[`EOC_RSVD_BIT] = 1'b0;
      ctrl_view[`EOC_RANGE_HI:`EOC_RANGE_LO] = state.range;
   end

   always_comb begin
      next_state = state;

      // Register write: the valid flag and the reserved bit are read only.
      if (wr && addr == `EOC_CTRL_ADDR) begin
         next_state.mode  = eoc_mode_t'(wdata[`EOC_MODE_HI:`EOC_MODE_LO]);
         next_state.range = wdata[`EOC_RANGE_HI:`EOC_RANGE_LO];
      end

      // Read data stand in the cycle after the strobe only.
      next_state.rdata = 8'h00;
      if (rd && addr == `EOC_CTRL_ADDR) begin
         next_state.rdata = ctrl_view;
      end

      // Amplitude-good level from the analog detector, three flip-flops.
      next_state.amp_sync = {state.amp_sync[1:0], amp_ok};
      if (state.amp_sync[1] == state.amp_sync[2]) begin
         next_state.amp_level = state.amp_sync[2];
      end

      // Crystal valid rises only after the amplitude has held good.
      if (dec_xtal && state.amp_level) begin
         if (state.qual_cnt >= QW'(QUAL_CYCLES)) begin
            next_state.valid = 1'b1;
         end else begin
            next_state.qual_cnt = state.qual_cnt + QW'(1);
            next_state.valid    = 1'b0;
         end
      end else begin
         next_state.qual_cnt = '0;
         next_state.valid    = 1'b0;
      end

      // Analog mode selects and pin claims follow the decoded mode, drive range the range field.
      next_state.osc_enable  = dec_on;
      next_state.crystal_sel = dec_xtal;
      next_state.rc_sel      = dec_rc;
      next_state.cap_sel     = dec_cap;
      next_state.cmos_sel    = dec_cmos;
      next_state.halve_sel   = dec_half;
      next_state.drive_range = state.range;
      next_state.in_claim    = dec_xtal;
      next_state.out_claim   = dec_on;

      next_state.tick = div_tick;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   eoc_edge_div #(
      .DIV (TIMER_DIV)
   ) u_div (
      .clock  (clock),
      .rstn   (rstn),
      .ce     (ce),
      .enable (state.osc_enable),
      .halve  (state.halve_sel),
      .raw_in (osc_raw),
      .tick   (div_tick)
   );

   assign rdata                = state.rdata;
   assign osc_enable           = state.osc_enable;
   assign crystal_sel          = state.crystal_sel;
   assign rc_sel               = state.rc_sel;
   assign cap_sel              = state.cap_sel;
   assign cmos_sel             = state.cmos_sel;
   assign halve_sel            = state.halve_sel;
   assign drive_range_select   = state.drive_range;
   assign osc_input_pin_claim  = state.in_claim;
   assign osc_output_pin_claim = state.out_claim;
   assign crystal_valid_flag   = state.valid;
   assign timer_tick           = state.tick;

endmodule : eoc_top

/* hdl/eoc_map.svh */
/*
 Register offset, field positions, reset value and timing counts of the
 external oscillator control block.
 Assumes a plain register port with an 8-bit address and 8-bit data.
*/
`ifndef EOC_MAP_SVH
`define EOC_MAP_SVH

`define EOC_ADDR_W            8
`define EOC_DATA_W            8
`define EOC_CTRL_ADDR         8'hB1
`define EOC_CTRL_RESET        8'h00

`define EOC_VALID_BIT         7
`define EOC_MODE_HI           6
`define EOC_MODE_LO           4
`define EOC_RSVD_BIT          3
`define EOC_RANGE_HI          2
`define EOC_RANGE_LO          0

`define EOC_CLK_PERIOD_NS     20
`define EOC_QUAL_TIME_NS      1000
`define EOC_QUAL_CYCLES       ((`EOC_QUAL_TIME_NS + `EOC_CLK_PERIOD_NS - 1) / `EOC_CLK_PERIOD_NS)
`define EOC_TIMER_DIV         8

`endif

/* hdl/eoc_pkg.sv */
/*
 Types shared by the external oscillator control block.
 Assumes nothing of its surroundings.
*/
package eoc_pkg;

   typedef enum logic [2:0] {
      EOC_MODE_OFF_A     = 3'b000,
      EOC_MODE_OFF_B     = 3'b001,
      EOC_MODE_CMOS      = 3'b010,
      EOC_MODE_CMOS_HALF = 3'b011,
      EOC_MODE_RC        = 3'b100,
      EOC_MODE_CAP       = 3'b101,
      EOC_MODE_XTAL      = 3'b110,
      EOC_MODE_XTAL_HALF = 3'b111
   } eoc_mode_t;

endpackage : eoc_pkg

/* hdl/eoc_edge_div.sv */
/*
 Synchroniser, edge detector and divider for the external oscillator.
 Produces a one-cycle enable pulse in the core clock domain every DIV
 rising edges of the raw oscillator, or every 2*DIV edges when halved.
 Assumes the raw oscillator runs no faster than a quarter of the core clock.
*/
`timescale 1ns/100ps
`include "eoc_map.svh"

module eoc_edge_div
   import eoc_pkg::*;
#(
   parameter int DIV = `EOC_TIMER_DIV
) (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic ce,
   input  wire logic enable,
   input  wire logic halve,
   input  wire logic raw_in,
   output logic      tick
);

   localparam int CW = $clog2(2 * DIV);

   generate
      if (DIV < 2) begin : g_bad_div
         $error("DIV must be at least 2.");
      end
   endgenerate

   typedef struct packed {
      logic [2:0]    sync;
      logic          level;
      logic [CW-1:0] cnt;
      logic          tick;
   } eoc_div_state_t;

   eoc_div_state_t state;
   eoc_div_state_t next_state;

   logic [CW-1:0] last_count;

   always_comb begin
      last_count = halve ? CW'(2 * DIV - 1) : CW'(DIV - 1);
      next_state = state;
      next_state.sync = {state.sync[1:0], raw_in};
      next_state.tick = 1'b0;
      if (state.sync[1] == state.sync[2]) begin
         next_state.level = state.sync[2];
      end
      if (!enable) begin
         next_state.cnt = '0;
      end else if (next_state.level && !state.level) begin
         if (state.cnt >= last_count) begin
            next_state.cnt  = '0;
            next_state.tick = 1'b1;
         end else begin
            next_state.cnt = state.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign tick = state.tick;

endmodule : eoc_edge_div

/* test/eoc_chk.sv */
/*
 Assertions on the ports of the external oscillator control block.
 Assumes it is bound into eoc_top and sees only its ports.
*/
`timescale 1ns/100ps
`include "eoc_map.svh"

module eoc_chk #(
   parameter int QUAL_CYCLES = `EOC_QUAL_CYCLES
) (
   input wire logic                   clock,
   input wire logic                   rstn,
   input wire logic                   ce,
   input wire logic                   wr,
   input wire logic [`EOC_ADDR_W-1:0] addr,
   input wire logic [`EOC_DATA_W-1:0] wdata,
   input wire logic                   amp_ok,
   input wire logic                   osc_enable,
   input wire logic                   crystal_sel,
   input wire logic                   rc_sel,
   input wire logic                   cap_sel,
   input wire logic                   cmos_sel,
   input wire logic                   halve_sel,
   input wire logic                   osc_input_pin_claim,
   input wire logic                   osc_output_pin_claim,
   input wire logic                   crystal_valid_flag,
   input wire logic                   timer_tick
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_ctrl_write;
      ce && wr && addr == `EOC_CTRL_ADDR;
   endsequence

   sequence s_decoded;
      ##2 osc_enable == ($past(wdata[6:5], 2) != 2'b00) && crystal_sel == &$past(wdata[6:5], 2);
   endsequence

   a_input_claim: assert property (osc_input_pin_claim == crystal_sel)
      else $error("input pin claim differs from crystal mode");
   a_output_claim: assert property (osc_output_pin_claim == osc_enable)
      else $error("output pin claim differs from circuit enable");
   a_write_decode: assert property (s_ctrl_write |-> s_decoded)
      else $error("mode write not decoded two cycles later");
   logic [3:0] sel;
   assign sel = {crystal_sel, rc_sel, cap_sel, cmos_sel};

   sequence s_settled;
      $past(amp_ok, QUAL_CYCLES) && crystal_sel;
   endsequence

   a_mode_off: assert property (!osc_enable |-> !(|sel || halve_sel))
      else $error("mode select active while circuit off");
   a_one_mode: assert property ($onehot0(sel) && osc_enable == |sel)
      else $error("mode selects not one-hot with enable");
   a_tick_gap: assert property (timer_tick |=> !timer_tick [*8])
      else $error("timer ticks too close together");
   a_tick_idle: assert property (!osc_enable [*8] |-> !timer_tick)
      else $error("timer tick while circuit off");
   a_valid_rise: assert property ($rose(crystal_valid_flag) |-> s_settled)
      else $error("valid rose without settled amplitude");
   a_valid_loss: assert property ($fell(amp_ok) |-> ##[1:6] !crystal_valid_flag)
      else $error("valid kept after amplitude loss");
   a_valid_mode: assert property (crystal_valid_flag |-> $past(crystal_sel))
      else $error("valid outside crystal mode");
endmodule : eoc_chk

bind eoc_top eoc_chk #(.QUAL_CYCLES(QUAL_CYCLES)) chk (.clock, .rstn, .ce, .wr, .addr, .wdata,
   .amp_ok, .osc_enable, .crystal_sel, .rc_sel, .cap_sel, .cmos_sel, .halve_sel,
   .osc_input_pin_claim, .osc_output_pin_claim, .crystal_valid_flag, .timer_tick);

/* test/eoc_osc_model.sv */
/*
 Behavioural external crystal or clock source.
 Assumes the block's enable and crystal select drive it; kill drops amplitude.
*/
`timescale 1ns/100ps

module eoc_osc_model (
   input  wire logic enable,
   input  wire logic crystal,
   input  wire logic kill,
   output logic      osc_raw,
   output logic      amp_ok
);
   initial begin
      osc_raw = 1'b0;
      #3;
      forever #50 osc_raw = enable ? ~osc_raw : 1'b0;
   end

   always begin
      amp_ok = 1'b0;
      wait (crystal && !kill);
      #200 amp_ok = crystal && !kill;
      wait (!crystal || kill);
   end
endmodule : eoc_osc_model

/* test/eoc_top_tb.sv */
/*
 Self-checking bench of the external oscillator control block.
 Assumes eoc_top, its checker and the oscillator model are compiled first.
*/
`timescale 1ns/100ps

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end

module eoc_top_tb;
   logic       clock, rstn, ce, wr, rd, kill, osc_raw, amp_ok, osc_enable, crystal_sel;
   logic       rc_sel, cap_sel, cmos_sel, halve_sel, timer_tick, crystal_valid_flag;
   logic       osc_input_pin_claim, osc_output_pin_claim;
   logic [7:0] addr, wdata, rdata, rv;
   logic [4:0] exp_sel;
   logic [2:0] drive_range_select;
   int         bad_count = 0, comparisons = 0, ticks = 0, tick_base = 0, lo = 0, hi = 0;

   eoc_top #(.QUAL_CYCLES(4)) dut (.clock, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata,
      .osc_raw, .amp_ok, .osc_enable, .crystal_sel, .rc_sel, .cap_sel, .cmos_sel, .halve_sel,
      .drive_range_select, .osc_input_pin_claim, .osc_output_pin_claim, .crystal_valid_flag,
      .timer_tick);
   eoc_osc_model osc (.enable(osc_output_pin_claim), .crystal(crystal_sel), .kill, .osc_raw,
      .amp_ok);

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   always @(negedge clock) if (timer_tick === 1'b1) ticks <= ticks + 1;

   task automatic print_verdict();
      if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      `CHK("rdata", e, d)
   endtask : rd_chk

   initial begin
      #1000000 bad_count++;
      print_verdict();
   end

   initial begin
      rstn = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; kill = 1'b0; addr = 8'h00; wdata = 8'h00;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      rd_chk(8'hB1, 8'h00);
      for (int m = 0; m < 8; m++) begin
         wr_reg(8'hB1, {1'b1, m[2:0], 1'b1, m[2:0]});
         repeat (2) @(negedge clock);
         exp_sel = {m[2:1] == 2'b11, m == 4, m == 5, m[2:1] == 2'b01, m == 3 || m == 7};
         `CHK("enable", m[2:1] != 2'b00, osc_enable)
         `CHK("in claim", exp_sel[4], osc_input_pin_claim)
         `CHK("out claim", m[2:1] != 2'b00, osc_output_pin_claim)
         `CHK("modes", exp_sel, {crystal_sel, rc_sel, cap_sel, cmos_sel, halve_sel})
         `CHK("range", m[2:0], drive_range_select)
         `CHK("valid early", 1'b0, crystal_valid_flag)
         rv = 8'h00;
         for (int i = 0; i < 64 && exp_sel[4] && !rv[7]; i++) rd_reg(8'hB1, rv);
         `CHK("valid poll", exp_sel[4], rv[7])
         tick_base = ticks;
         repeat (400) @(posedge clock);
         @(negedge clock);
         lo = (m < 2) ? 0 : (m == 3 || m == 7) ? 4 : 9;
         hi = (m < 2) ? 0 : lo + 1;
         `CHK("ticks", 1'b1, (ticks - tick_base) inside {[lo:hi]})
         rd_chk(8'hB1, {exp_sel[4], m[2:0], 1'b0, m[2:0]});
         if (exp_sel[4]) begin
            kill <= 1'b1;
            repeat (8) @(posedge clock);
            @(negedge clock);
            `CHK("valid", 1'b0, crystal_valid_flag)
            kill <= 1'b0;
         end
         wr_reg(8'hB1, 8'h00);
      end
      repeat (2) @(posedge clock);
      ce <= 1'b0;
      wr_reg(8'hB1, 8'h62);
      ce <= 1'b1;
      rd_chk(8'hB1, 8'h00);
      `CHK("frozen", 1'b0, osc_enable)
      wr_reg(8'hB0, 8'h65);
      rd_chk(8'hB0, 8'h00);
      rd_chk(8'hB1, 8'h00);
      wr_reg(8'hB1, 8'h67);
      rd_chk(8'hB1, 8'h67);
      @(negedge clock);
      `CHK("rdata idle", 8'h00, rdata)
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      `CHK("reset enable", 1'b0, osc_enable)
      `CHK("reset claim", 1'b0, osc_output_pin_claim)
      `CHK("reset range", 3'h0, drive_range_select)
      rd_chk(8'hB1, 8'h00);
      print_verdict();
   end
endmodule : eoc_top_tb
